// ---- rtl/hrs_pkg.sv ----
// constants and types for the hardware reset sequencer
package hrs_pkg;
    localparam int unsigned CLK_MHZ = 100;
    localparam int unsigned SPIKE_MAX_US = 5;
    localparam int unsigned RESET_MIN_US = 9;
    localparam int unsigned GLITCH_MAX_US = 5;
    localparam int unsigned RELOAD_MAX_MS = 5;
    localparam int unsigned BLANK_MAX_MS = 120;
    localparam int unsigned RESET_CYC = RESET_MIN_US * CLK_MHZ - 1;
    localparam int unsigned GLITCH_CYC = GLITCH_MAX_US * CLK_MHZ;
    localparam int unsigned RELOAD_CYC = RELOAD_MAX_MS * 1000 * CLK_MHZ;
    localparam int unsigned BLANK_CYC = BLANK_MAX_MS * 1000 * CLK_MHZ;
    localparam int unsigned NVM_WORDS = 8;
    localparam int unsigned NVM_AW = 3;
    localparam int unsigned DW = 8;
    localparam int unsigned CW = 24;
    localparam logic [CW-1:0] CNT_ZERO = 24'h00_0000;
    localparam logic [CW-1:0] CNT_ONE = 24'h00_0001;
    localparam logic [NVM_AW-1:0] ADDR_ZERO = 3'h0;
    localparam logic [NVM_AW-1:0] ADDR_LAST = 3'h7;
    localparam logic [DW-1:0] BYTE_ZERO = 8'h00;
    localparam logic [DW-1:0] CVOLT_DEF = 8'h00;
    localparam int unsigned CVOLT_IDX = 3;
    typedef enum logic [3:0] {
        HRS_RUN = 4'b0001,
        HRS_HELD = 4'b0010,
        HRS_BLANK = 4'b0100,
        HRS_LOAD = 4'b1000
    } hrs_state_t;
endpackage

// ---- rtl/hrs_nvm_if.sv ----
// read port between the sequencer and the settings memory
interface hrs_nvm_if;
    logic rd_en;
    logic [hrs_pkg::NVM_AW-1:0] rd_addr;
    logic [hrs_pkg::DW-1:0] rd_data;
    modport master (output rd_en, output rd_addr, input rd_data);
    modport slave (input rd_en, input rd_addr, output rd_data);
endinterface

// ---- rtl/hrs_nvm.sv ----
// non-volatile settings store, registered read data
module hrs_nvm (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // read port
    hrs_nvm_if.slave nvm,
    // factory write port
    input wire logic wr_en_i,
    input wire logic [hrs_pkg::NVM_AW-1:0] wr_addr_i,
    input wire logic [hrs_pkg::DW-1:0] wr_data_i
);
    import hrs_pkg::*;
    logic [DW-1:0] mem [NVM_WORDS];
    logic [DW-1:0] rd_reg;
    // storage array, no reset so it maps onto memory
    always_ff @(posedge sys_clk_i) begin
        if (wr_en_i) begin
            mem[wr_addr_i] <= wr_data_i;
        end
    end
    // read data always from a register
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rd_reg <= BYTE_ZERO;
        end else if (nvm.rd_en) begin
            rd_reg <= mem[nvm.rd_addr];
        end
    end
    assign nvm.rd_data = rd_reg;
endmodule

// ---- rtl/hrs_top.sv ----
// hardware reset sequencer: filters the reset pin, blanks, reloads settings
module hrs_top (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    // reset pin from the host, active low
    input wire logic hw_reset_n_i,
    // device sleep state from the command core
    input wire logic sleep_in_i,
    // factory programming of the settings store
    input wire logic nvm_wr_en_i,
    input wire logic [hrs_pkg::NVM_AW-1:0] nvm_wr_addr_i,
    input wire logic [hrs_pkg::DW-1:0] nvm_wr_data_i,
    // status to the rest of the controller
    output logic core_rst_n_o,
    output logic blank_o,
    output logic ready_o,
    output logic [hrs_pkg::DW-1:0] common_voltage_setting_o,
    output logic [hrs_pkg::DW*hrs_pkg::NVM_WORDS-1:0] settings_o
);
    import hrs_pkg::*;

    function automatic logic [CW-1:0] cnt_inc(input logic [CW-1:0] c);
        cnt_inc = c + CNT_ONE;
    endfunction

    hrs_nvm_if nvm ();
    hrs_nvm u_nvm (
        .sys_clk_i (sys_clk_i),
        .rstn_i (rstn_i),
        .nvm (nvm),
        .wr_en_i (nvm_wr_en_i),
        .wr_addr_i (nvm_wr_addr_i),
        .wr_data_i (nvm_wr_data_i)
    );

    // pin synchroniser, first stage read only by the second
    logic pin_s1_reg, pin_s2_reg;
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_s1_reg <= 1'b1;
            pin_s2_reg <= 1'b1;
        end else begin
            pin_s1_reg <= hw_reset_n_i;
            pin_s2_reg <= pin_s1_reg;
        end
    end

    hrs_state_t state_reg;
    logic [CW-1:0] low_cnt_reg, high_cnt_reg, seq_cnt_reg;
    logic slept_reg;
    logic [NVM_AW-1:0] ld_addr_reg;
    logic ld_pend_reg, ld_done_reg;
    logic [NVM_AW-1:0] ld_wr_addr_reg;

    // low-time counter; a confirmed low is held so short highs do not clear it
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            low_cnt_reg <= CNT_ZERO;
        end else if (!pin_s2_reg) begin
            if (low_cnt_reg != CW'(RESET_CYC)) begin
                low_cnt_reg <= cnt_inc(low_cnt_reg);
            end
        end else if (state_reg != HRS_HELD) begin
            low_cnt_reg <= CNT_ZERO; // short spikes leave no trace
        end
    end

    // high-time counter measures glitches inside a held reset
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            high_cnt_reg <= CNT_ZERO;
        end else if (pin_s2_reg && state_reg == HRS_HELD) begin
            high_cnt_reg <= cnt_inc(high_cnt_reg);
        end else begin
            high_cnt_reg <= CNT_ZERO;
        end
    end

    // main sequence; a fresh valid low restarts it from any state
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= HRS_LOAD;
            slept_reg <= 1'b1;
            seq_cnt_reg <= CNT_ZERO;
        end else begin
            case (state_reg)
                HRS_RUN, HRS_BLANK, HRS_LOAD: begin
                    // 5..9 us pulses fall short of the threshold: no reset
                    if (!pin_s2_reg && low_cnt_reg == CW'(RESET_CYC)) begin
                        state_reg <= HRS_HELD;
                        // sleep state is sampled only when a running device is reset
                        slept_reg <= (state_reg == HRS_RUN) ? sleep_in_i : slept_reg;
                        seq_cnt_reg <= CNT_ZERO;
                    end else if (state_reg == HRS_LOAD) begin
                        // reload comes first on every release so it ends inside 5 ms
                        if (ld_done_reg) begin
                            state_reg <= slept_reg ? HRS_RUN : HRS_BLANK;
                            seq_cnt_reg <= CNT_ZERO;
                        end
                    end else if (state_reg == HRS_BLANK) begin
                        seq_cnt_reg <= cnt_inc(seq_cnt_reg);
                        // blanking tail keeps the whole release inside 120 ms
                        if (seq_cnt_reg == CW'(BLANK_CYC - RELOAD_CYC - 1)) begin
                            state_reg <= HRS_RUN;
                        end
                    end
                end
                HRS_HELD: begin
                    // release only after a high longer than the glitch limit
                    if (pin_s2_reg && high_cnt_reg == CW'(GLITCH_CYC)) begin
                        state_reg <= HRS_LOAD;
                        seq_cnt_reg <= CNT_ZERO;
                    end
                end
                default: state_reg <= HRS_LOAD;
            endcase
        end
    end

    // reload walk: clear settings, then copy every word from the store
    logic [DW*NVM_WORDS-1:0] set_reg;
    assign nvm.rd_en = (state_reg == HRS_LOAD) && !ld_done_reg;
    assign nvm.rd_addr = ld_addr_reg;
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ld_addr_reg <= ADDR_ZERO;
            ld_pend_reg <= 1'b0;
            ld_done_reg <= 1'b0;
            ld_wr_addr_reg <= ADDR_ZERO;
            set_reg <= '0;
        end else if (state_reg != HRS_LOAD) begin
            ld_addr_reg <= ADDR_ZERO;
            ld_pend_reg <= 1'b0;
            ld_done_reg <= 1'b0;
            if (state_reg == HRS_HELD) begin
                set_reg <= '0;
            end
        end else if (!ld_done_reg) begin
            ld_pend_reg <= 1'b1;
            ld_wr_addr_reg <= ld_addr_reg;
            if (ld_pend_reg) begin
                set_reg[ld_wr_addr_reg*DW +: DW] <= nvm.rd_data;
                if (ld_wr_addr_reg == ADDR_LAST) begin
                    ld_done_reg <= 1'b1;
                end
            end
            if (ld_addr_reg != ADDR_LAST) begin
                ld_addr_reg <= ld_addr_reg + 3'h1;
            end
        end
    end

    // outputs straight from flip-flops
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            core_rst_n_o <= 1'b0;
            blank_o <= 1'b1;
            ready_o <= 1'b0;
            common_voltage_setting_o <= CVOLT_DEF;
            settings_o <= '0;
        end else begin
            core_rst_n_o <= (state_reg == HRS_RUN);
            blank_o <= (state_reg != HRS_RUN);
            ready_o <= (state_reg == HRS_RUN);
            common_voltage_setting_o <= set_reg[CVOLT_IDX*DW +: DW];
            settings_o <= set_reg;
        end
    end

    // checks
    // release timer: from the synced rising pin through the reload, cleared by a new low
    logic [CW-1:0] rel_cnt_reg;
    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rel_cnt_reg <= CNT_ZERO;
        end else if (state_reg == HRS_LOAD || (state_reg == HRS_HELD && pin_s2_reg)) begin
            if (rel_cnt_reg != {CW{1'b1}}) begin
                rel_cnt_reg <= cnt_inc(rel_cnt_reg); // saturates so it never wraps back
            end
        end else begin
            rel_cnt_reg <= CNT_ZERO;
        end
    end
    sequence valid_low_s;
        !pin_s2_reg && low_cnt_reg == CW'(RESET_CYC);
    endsequence
    sequence sleep_release_s;
        state_reg == HRS_HELD && slept_reg && pin_s2_reg && high_cnt_reg == CW'(GLITCH_CYC);
    endsequence
    spike_reject_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (state_reg == HRS_RUN && low_cnt_reg < CW'(RESET_CYC)) |=> state_reg != HRS_HELD)
        else $error("short low pulse entered reset");
    reset_take_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        ((state_reg == HRS_RUN) and valid_low_s) |=> state_reg == HRS_HELD)
        else $error("valid low pulse missed");
    glitch_hold_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (state_reg == HRS_HELD && high_cnt_reg < CW'(GLITCH_CYC)) |=> state_reg == HRS_HELD)
        else $error("glitch ended reset");
    load_time_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        rel_cnt_reg <= CW'(RELOAD_CYC))
        else $error("reload exceeded limit");
    sleep_path_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        sleep_release_s |-> ##[1:600] ready_o)
        else $error("sleep release too slow");
    blank_out_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        state_reg == HRS_HELD |=> blank_o)
        else $error("display not blanked");
    defaults_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        state_reg == HRS_HELD |=> set_reg == '0)
        else $error("settings not cleared");
    reload_copy_a: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
        (state_reg == HRS_LOAD && ld_pend_reg && !ld_done_reg) |=>
        set_reg[$past(ld_wr_addr_reg)*DW +: DW] == $past(nvm.rd_data))
        else $error("settings word not copied");
endmodule

// ---- testbench/hrs_host_model.sv ----
// host-side model that drives the reset pin of the sequencer
module hrs_host_model (
    // clock
    input wire logic sys_clk_i,
    // reset pin to the device, active low
    output logic hw_reset_n_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // the pin idles high; no commands are sent, so post-release waits hold
    initial hw_reset_n_o = 1'b1;
    // round a time in ns up to whole 10 ns cycles, never short of the target
    function automatic int to_cyc(input int ns);
        return (ns + 9) / 10;
    endfunction
    // low pulse of low_ns plus one cycle, with an optional high glitch of gl_cyc cycles after gl_at + 1 low cycles
    task automatic pulse(input int low_ns, input int gl_at, input int gl_cyc);
        int n;
        n = to_cyc(low_ns);
        @(posedge sys_clk_i);
        hw_reset_n_o <= 1'b0;
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk_i);
            if (gl_cyc > 0 && i == gl_at) hw_reset_n_o <= 1'b1;
            if (gl_cyc > 0 && i == gl_at + gl_cyc) hw_reset_n_o <= 1'b0;
        end
        @(posedge sys_clk_i);
        hw_reset_n_o <= 1'b1;
    endtask
endmodule

// ---- testbench/hrs_top_bench.sv ----
// self-checking bench for the hardware reset sequencer
module hrs_top_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import hrs_pkg::*;
    logic sys_clk_i, rstn_i, sleep_in_i, nvm_wr_en_i, hw_reset_n, dropped;
    logic core_rst_n_o, blank_o, ready_o;
    logic [NVM_AW-1:0] nvm_wr_addr_i;
    logic [DW-1:0] nvm_wr_data_i, common_voltage_setting_o;
    logic [DW*NVM_WORDS-1:0] settings_o, exp_set, seen_set, note_set;
    logic [DW*NVM_WORDS-1:0] note_q[$];
    int err_count = 0;
    int checks = 0;
    int spk[2] = '{4000, 8000};
    hrs_top i_dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .hw_reset_n_i(hw_reset_n),
        .sleep_in_i(sleep_in_i), .nvm_wr_en_i(nvm_wr_en_i), .nvm_wr_addr_i(nvm_wr_addr_i),
        .nvm_wr_data_i(nvm_wr_data_i), .core_rst_n_o(core_rst_n_o), .blank_o(blank_o),
        .ready_o(ready_o), .common_voltage_setting_o(common_voltage_setting_o),
        .settings_o(settings_o));
    hrs_host_model u_host (.sys_clk_i(sys_clk_i), .hw_reset_n_o(hw_reset_n));
    // one comparison; a mismatch is reported and counted at once
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        checks++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        $display("mismatches %0d, comparisons %0d", err_count, checks);
        if (err_count == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // bounded wait for ready; running out ends the run as a mismatch
    task automatic wait_ready(input int lim);
        int n;
        n = 0;
        while (ready_o !== 1'b1 && n < lim) begin
            @(negedge sys_clk_i);
            n++;
        end
        if (ready_o !== 1'b1) begin
            err_count++;
            final_report();
        end
    endtask
    initial begin
        sys_clk_i = 1'b0;
        forever #5 sys_clk_i = ~sys_clk_i;
    end
    // any lapse of ready while a spike is applied is remembered
    always @(negedge sys_clk_i) begin
        if (ready_o !== 1'b1) dropped <= 1'b1;
    end
    // when ready rises the reloaded words are compared with the oldest note
    always @(posedge ready_o) begin
        #1;
        if (note_q.size() > 0) begin
            note_set = note_q.pop_front();
            seen_set = settings_o;
            check(seen_set, note_set);
            check(64'(common_voltage_setting_o), 64'(note_set[DW*CVOLT_IDX +: DW]));
            check(64'(blank_o), 64'h0);
            check(64'(core_rst_n_o), 64'h1);
        end
    end
    initial begin
        logic [DW-1:0] b;
        int g;
        rstn_i = 1'b0;
        sleep_in_i = 1'b1;
        nvm_wr_en_i = 1'b0;
        nvm_wr_addr_i = ADDR_ZERO;
        nvm_wr_data_i = BYTE_ZERO;
        dropped = 1'b0;
        exp_set = '0;
        void'($urandom(23863));
        repeat (3) @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        wait_ready(1000);
        // program random words; a clean pulse from sleep must reload them
        for (int i = 0; i < NVM_WORDS; i++) begin
            b = DW'($urandom);
            @(posedge sys_clk_i);
            nvm_wr_en_i <= 1'b1;
            nvm_wr_addr_i <= NVM_AW'(i);
            nvm_wr_data_i <= b;
            exp_set[DW*i +: DW] = b;
        end
        @(posedge sys_clk_i);
        nvm_wr_en_i <= 1'b0;
        note_q.push_back(exp_set);
        fork
            u_host.pulse(10000, 0, 0);
            begin
                repeat (950) @(negedge sys_clk_i);
                check(64'(blank_o), 64'h1);
                check(64'(ready_o), 64'h0);
                check(settings_o, 64'h0);
            end
        join
        wait_ready(5000);
        // spikes below the reset threshold must leave the device running
        foreach (spk[k]) begin
            repeat (2) @(negedge sys_clk_i);
            dropped = 1'b0;
            u_host.pulse(spk[k], 0, 0);
            repeat (1200) @(negedge sys_clk_i);
            check(64'(dropped), 64'h0);
        end
        // a high glitch shorter than 5 us inside a valid pulse keeps reset
        g = 100 + int'($urandom % 400);
        note_q.push_back(exp_set);
        u_host.pulse((1300 + g) * 10, 1000, g);
        @(negedge sys_clk_i);
        check(64'(ready_o), 64'h0);
        wait_ready(5000);
        // taken while awake the blanking outlasts the sleep path
        @(posedge sys_clk_i);
        sleep_in_i <= 1'b0;
        u_host.pulse(10000, 0, 0);
        repeat (2000) @(negedge sys_clk_i);
        check(64'(blank_o), 64'h1);
        check(64'(ready_o), 64'h0);
        check(settings_o, exp_set);
        // a device reset in mid-blank returns the outputs to defaults; the stored words are kept
        @(posedge sys_clk_i);
        rstn_i <= 1'b0;
        sleep_in_i <= 1'b1;
        @(negedge sys_clk_i);
        check(64'(core_rst_n_o), 64'h0);
        check(settings_o, 64'h0);
        note_q.push_back(exp_set);
        @(posedge sys_clk_i);
        rstn_i <= 1'b1;
        wait_ready(1000);
        final_report();
    end
endmodule
